// File: src/ltr_pkg.sv
// constants, register map and state encodings of the line thermal replica
// assumes a single 100 MHz clock and an avalon-mm slave with 32-bit data
package ltr_pkg;
	// clock and calculation rate
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CALC_HZ = 1_000;
	localparam int unsigned TICK_CYC = CLK_HZ / CALC_HZ;
	// model step dt in ms, and steps per minute for the time constant
	localparam int unsigned STEP_MS = 1;
	localparam int unsigned STEPS_MIN = 60_000 / STEP_MS;
	// rms block window is 2**RMS_LOG2 samples
	localparam int unsigned RMS_LOG2 = 4;
	// sample counts that make one percent of rated current
	localparam int unsigned CUR_PER_PCT = 10;
	// one percent as a Q8.32 fraction, rounded
	localparam logic [39:0] PCT_Q32 = 40'h00028F5C29;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ALM = 8'h04;
	localparam logic [7:0] OFS_TRP = 8'h08;
	localparam logic [7:0] OFS_RTD = 8'h0C;
	localparam logic [7:0] OFS_BASE = 8'h10;
	localparam logic [7:0] OFS_UNL = 8'h14;
	localparam logic [7:0] OFS_AMB = 8'h18;
	localparam logic [7:0] OFS_STRT = 8'h1C;
	localparam logic [7:0] OFS_INOM = 8'h20;
	localparam logic [7:0] OFS_TC = 8'h24;
	localparam logic [7:0] OFS_STAT = 8'h28;
	localparam logic [7:0] OFS_TEMP = 8'h2C;
	localparam logic [7:0] OFS_LVL = 8'h30;
	localparam logic [7:0] OFS_RMS1 = 8'h34;
	localparam logic [7:0] OFS_RMS2 = 8'h38;
	localparam logic [7:0] OFS_RMS3 = 8'h3C;
	// control bit positions
	localparam int unsigned CTRL_SENS = 2;
	localparam int unsigned CTRL_BLK = 3;
	localparam int unsigned CTRL_HRST = 4;
	// operating modes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_PULSED = 2'h1;
	localparam logic [1:0] MODE_LOCKED = 2'h2;
	// setting ranges and reset values
	localparam logic [9:0] ALM_MIN = 10'h03C, ALM_MAX = 10'h0C8, ALM_DEF = 10'h050;
	localparam logic [9:0] TRP_MIN = 10'h03C, TRP_MAX = 10'h0C8, TRP_DEF = 10'h064;
	localparam logic [9:0] RTD_MIN = 10'h03C, RTD_MAX = 10'h0C8, RTD_DEF = 10'h064;
	localparam logic [9:0] BASE_MIN = 10'h000, BASE_MAX = 10'h028, BASE_DEF = 10'h019;
	localparam logic [9:0] UNL_MIN = 10'h014, UNL_MAX = 10'h0C8, UNL_DEF = 10'h03C;
	localparam logic [9:0] AMB_MIN = 10'h000, AMB_MAX = 10'h028, AMB_DEF = 10'h019;
	localparam logic [9:0] STRT_MIN = 10'h000, STRT_MAX = 10'h03C, STRT_DEF = 10'h000;
	localparam logic [9:0] INOM_MIN = 10'h014, INOM_MAX = 10'h096, INOM_DEF = 10'h064;
	localparam logic [9:0] TC_MIN = 10'h001, TC_MAX = 10'h3E7, TC_DEF = 10'h00A;
	// calculation sequencer
	typedef enum logic [2:0] {ST_IDLE, ST_SQRT, ST_MAX, ST_XDIV, ST_DDIV, ST_UPD} ltr_state_t;
endpackage

// File: src/ltr_thermal_replica.sv
// line thermal replica: per-phase rms, max select, first-order model, thresholds
// assumes samples and ambient value come from logic on ref_clk, registers over avalon-mm
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module ltr_thermal_replica #(
	parameter int unsigned TICK_CYCLES = ltr_pkg::TICK_CYC // cycles per model step
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic rst_b, // async reset, active low
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // write byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall until answered
	input wire logic [15:0] phase1_sample, // signed phase current sample
	input wire logic [15:0] phase2_sample, // signed phase current sample
	input wire logic [15:0] phase3_sample, // signed phase current sample
	input wire logic [7:0] ambient_sensor_temp, // measured ambient, deg
	output logic alarm_out, // alarm status
	output logic trip_out, // general trip
	output logic lock_out // reclose locked
);

	typedef struct packed {
		ltr_pkg::ltr_state_t st;
		logic [16:0] tick_cnt;
		logic [1:0] mode;
		logic sens;
		logic blk;
		logic hrst;
		logic [9:0] alm;
		logic [9:0] trp;
		logic [9:0] rtd;
		logic [9:0] base;
		logic [9:0] unl;
		logic [9:0] amb;
		logic [9:0] strt;
		logic [9:0] inom;
		logic [9:0] tc;
		logic [3:0] win;
		logic [2:0][35:0] acc;
		logic [2:0][31:0] ms;
		logic [2:0][15:0] rms;
		logic [15:0] root;
		logic [1:0] ph;
		logic [3:0] bi;
		logic [15:0] imax;
		logic [63:0] num;
		logic [63:0] quo;
		logic [31:0] den;
		logic [31:0] rem;
		logic [5:0] dcnt;
		logic [39:0] lvl;
		logic up;
		logic [15:0] temp;
		logic above;
		logic alarm;
		logic trip;
		logic lock;
		logic ack;
		logic [31:0] rdata;
	} ltr_regs_t;

	localparam ltr_regs_t RST_S = '{
		st: ltr_pkg::ST_IDLE,
		mode: ltr_pkg::MODE_PULSED,
		alm: ltr_pkg::ALM_DEF,
		trp: ltr_pkg::TRP_DEF,
		rtd: ltr_pkg::RTD_DEF,
		base: ltr_pkg::BASE_DEF,
		unl: ltr_pkg::UNL_DEF,
		amb: ltr_pkg::AMB_DEF,
		strt: ltr_pkg::STRT_DEF,
		inom: ltr_pkg::INOM_DEF,
		tc: ltr_pkg::TC_DEF,
		default: '0
	};

	ltr_regs_t s_r;
	ltr_regs_t s_nxt;
	logic [2:0][15:0] smp;
	logic [2:0][31:0] sq;
	logic tick;
	logic req;
	logic en;
	logic [9:0] amb_use;
	logic [9:0] thn;
	logic [47:0] temp_q;
	logic above_c;
	logic alarm_c;
	logic below_unl;
	logic [15:0] trial;
	logic [15:0] root_n;
	logic [15:0] imax_c;
	logic [15:0] in_c;
	logic [32:0] div_rs;
	logic div_ge;
	logic [63:0] quo_f;
	logic [39:0] x_sat;
	logic [31:0] rd;
	logic [31:0] bem;
	logic [31:0] wm;

	// squares without the signed 16-bit context shrinking them
	function automatic logic [31:0] sqr(input logic [15:0] v);
		logic signed [31:0] w;
		w = 32'($signed(v));
		return 32'(w * w);
	endfunction

	// saturate a written setting into its legal range
	function automatic logic [9:0] clampv(input logic [31:0] v, input logic [9:0] lo,
		input logic [9:0] hi);
		if (v < 32'(lo))
			return lo;
		else if (v > 32'(hi))
			return hi;
		return v[9:0];
	endfunction

	// a whole-degree value as Q16.32
	function automatic logic [47:0] deg48(input logic [9:0] v);
		return {6'h0, v, 32'h0};
	endfunction

	// register read mux, unmapped offsets read zero
	function automatic logic [31:0] rd_mux(input ltr_regs_t r, input logic [7:0] a);
		case (a)
			ltr_pkg::OFS_CTRL: return {28'h0, r.blk, r.sens, r.mode};
			ltr_pkg::OFS_ALM: return {22'h0, r.alm};
			ltr_pkg::OFS_TRP: return {22'h0, r.trp};
			ltr_pkg::OFS_RTD: return {22'h0, r.rtd};
			ltr_pkg::OFS_BASE: return {22'h0, r.base};
			ltr_pkg::OFS_UNL: return {22'h0, r.unl};
			ltr_pkg::OFS_AMB: return {22'h0, r.amb};
			ltr_pkg::OFS_STRT: return {22'h0, r.strt};
			ltr_pkg::OFS_INOM: return {22'h0, r.inom};
			ltr_pkg::OFS_TC: return {22'h0, r.tc};
			ltr_pkg::OFS_STAT: return {28'h0, r.above, r.lock, r.trip, r.alarm};
			ltr_pkg::OFS_TEMP: return {16'h0, r.temp};
			ltr_pkg::OFS_LVL: return r.lvl[39:8];
			ltr_pkg::OFS_RMS1: return {16'h0, r.rms[0]};
			ltr_pkg::OFS_RMS2: return {16'h0, r.rms[1]};
			ltr_pkg::OFS_RMS3: return {16'h0, r.rms[2]};
			default: return 32'h0;
		endcase
	endfunction

	// sample squares, step tick
	assign smp = {phase3_sample, phase2_sample, phase1_sample};
	assign sq = {sqr(smp[2]), sqr(smp[1]), sqr(smp[0])};
	assign tick = (s_r.tick_cnt == 17'(TICK_CYCLES - 1));
	assign en = (s_r.mode != ltr_pkg::MODE_OFF) && !s_r.blk;

	// temperature path
	assign amb_use = s_r.sens ? {2'h0, ambient_sensor_temp} : s_r.amb;
	assign thn = s_r.rtd - s_r.base;
	assign temp_q = 48'(s_r.lvl) * 48'(thn) + deg48(amb_use);
	assign above_c = temp_q > deg48(s_r.trp);
	assign alarm_c = temp_q > deg48(s_r.alm);
	assign below_unl = temp_q < deg48(s_r.unl);

	// bitwise square root, one result bit per cycle
	assign trial = s_r.root | (16'h1 << s_r.bi);
	assign root_n = (32'(trial) * 32'(trial) <= s_r.ms[s_r.ph]) ? trial : s_r.root;

	// largest phase and rated current in sample counts
	assign imax_c = (s_r.rms[0] >= s_r.rms[1] && s_r.rms[0] >= s_r.rms[2]) ? s_r.rms[0] :
		(s_r.rms[1] >= s_r.rms[2]) ? s_r.rms[1] : s_r.rms[2];
	assign in_c = 16'(s_r.inom) * 16'(ltr_pkg::CUR_PER_PCT);

	// shared restoring divider, one quotient bit per cycle
	assign div_rs = {s_r.rem, s_r.num[63]};
	assign div_ge = div_rs >= {1'b0, s_r.den};
	assign quo_f = {s_r.quo[62:0], div_ge};
	assign x_sat = (|quo_f[63:40]) ? 40'hFF_FFFF_FFFF : quo_f[39:0];

	// bus: one wait cycle, then the answer
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !s_r.ack;
	assign avs_readdata = s_r.rdata;
	assign rd = rd_mux(s_r, avs_address);
	assign bem = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wm = (rd & ~bem) | (avs_writedata & bem);

	assign alarm_out = s_r.alarm;
	assign trip_out = s_r.trip;
	assign lock_out = s_r.lock;

	// next state: step sequencer, then bus writes so a new heat reset is never lost
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick_cnt = tick ? 17'h0 : s_r.tick_cnt + 17'h1;
		case (s_r.st)
			ltr_pkg::ST_IDLE: begin
				if (tick) begin
					s_nxt.win = s_r.win + 4'h1;
					for (int k = 0; k < 3; k++) begin
						s_nxt.acc[k] = s_r.acc[k] + 36'(sq[k]);
						if (s_r.win == 4'hF) begin
							s_nxt.ms[k] = 32'((s_r.acc[k] + 36'(sq[k])) >> ltr_pkg::RMS_LOG2);
							s_nxt.acc[k] = 36'h0;
						end
					end
					s_nxt.ph = 2'h0;
					s_nxt.bi = 4'hF;
					s_nxt.root = 16'h0;
					// roots redone every step: fixed step latency keeps a trip pulse one step
					s_nxt.st = ltr_pkg::ST_SQRT;
				end
			end
			ltr_pkg::ST_SQRT: begin
				s_nxt.root = root_n;
				s_nxt.bi = s_r.bi - 4'h1;
				if (s_r.bi == 4'h0) begin
					s_nxt.rms[s_r.ph] = root_n;
					s_nxt.root = 16'h0;
					s_nxt.ph = s_r.ph + 2'h1;
					if (s_r.ph == 2'h2)
						s_nxt.st = ltr_pkg::ST_MAX;
				end
			end
			ltr_pkg::ST_MAX: begin
				s_nxt.imax = imax_c;
				s_nxt.num = {32'(imax_c) * 32'(imax_c), 32'h0};
				s_nxt.den = 32'(in_c) * 32'(in_c);
				s_nxt.rem = 32'h0;
				s_nxt.quo = 64'h0;
				s_nxt.dcnt = 6'h0;
				s_nxt.st = ltr_pkg::ST_XDIV;
			end
			ltr_pkg::ST_XDIV, ltr_pkg::ST_DDIV: begin
				s_nxt.rem = div_ge ? 32'(div_rs - {1'b0, s_r.den}) : div_rs[31:0];
				s_nxt.quo = quo_f;
				s_nxt.num = {s_r.num[62:0], 1'b0};
				s_nxt.dcnt = s_r.dcnt + 6'h1;
				if (s_r.dcnt == 6'h3F) begin
					s_nxt.rem = 32'h0;
					s_nxt.quo = 64'h0;
					if (s_r.st == ltr_pkg::ST_XDIV) begin
						// x is (i/in)^2; next divide the gap to the level by T/dt
						s_nxt.up = x_sat >= s_r.lvl;
						s_nxt.num = {24'h0, (x_sat >= s_r.lvl) ? x_sat - s_r.lvl : s_r.lvl - x_sat};
						s_nxt.den = 32'(s_r.tc) * 32'(ltr_pkg::STEPS_MIN);
						s_nxt.st = ltr_pkg::ST_DDIV;
					end else begin
						// gap shrinks by dt/T; small gaps round to no change
						s_nxt.lvl = s_r.up ? s_r.lvl + quo_f[39:0] : s_r.lvl - quo_f[39:0];
						s_nxt.st = ltr_pkg::ST_UPD;
					end
				end
			end
			ltr_pkg::ST_UPD: begin
				s_nxt.temp = temp_q[47:32];
				s_nxt.above = above_c;
				s_nxt.alarm = en && alarm_c;
				if (s_r.mode == ltr_pkg::MODE_LOCKED) begin
					s_nxt.lock = en && (above_c || (s_r.lock && !below_unl));
					s_nxt.trip = s_nxt.lock;
				end else begin
					s_nxt.trip = en && above_c && !s_r.above;
					s_nxt.lock = 1'b0;
				end
				if (s_r.hrst) begin
					s_nxt.lvl = 40'(s_r.strt) * ltr_pkg::PCT_Q32;
					s_nxt.hrst = 1'b0;
				end
				s_nxt.st = ltr_pkg::ST_IDLE;
			end
			default: s_nxt.st = ltr_pkg::ST_IDLE;
		endcase
		// off or blocked drops alarm, trip and lock at once
		if (!en) begin
			s_nxt.alarm = 1'b0;
			s_nxt.trip = 1'b0;
			s_nxt.lock = 1'b0;
		end
		// answer one cycle after the request appears
		s_nxt.ack = req && !s_r.ack;
		if (req && !s_r.ack)
			s_nxt.rdata = rd;
		if (avs_write && s_r.ack) begin
			case (avs_address)
				ltr_pkg::OFS_CTRL: begin
					s_nxt.mode = (wm[1:0] == 2'h3) ? ltr_pkg::MODE_LOCKED : wm[1:0];
					s_nxt.sens = wm[ltr_pkg::CTRL_SENS];
					s_nxt.blk = wm[ltr_pkg::CTRL_BLK];
					if (wm[ltr_pkg::CTRL_HRST])
						s_nxt.hrst = 1'b1;
				end
				ltr_pkg::OFS_ALM: s_nxt.alm = clampv(wm, ltr_pkg::ALM_MIN, ltr_pkg::ALM_MAX);
				ltr_pkg::OFS_TRP: s_nxt.trp = clampv(wm, ltr_pkg::TRP_MIN, ltr_pkg::TRP_MAX);
				ltr_pkg::OFS_RTD: s_nxt.rtd = clampv(wm, ltr_pkg::RTD_MIN, ltr_pkg::RTD_MAX);
				ltr_pkg::OFS_BASE: s_nxt.base = clampv(wm, ltr_pkg::BASE_MIN, ltr_pkg::BASE_MAX);
				ltr_pkg::OFS_UNL: s_nxt.unl = clampv(wm, ltr_pkg::UNL_MIN, ltr_pkg::UNL_MAX);
				ltr_pkg::OFS_AMB: s_nxt.amb = clampv(wm, ltr_pkg::AMB_MIN, ltr_pkg::AMB_MAX);
				ltr_pkg::OFS_STRT: s_nxt.strt = clampv(wm, ltr_pkg::STRT_MIN, ltr_pkg::STRT_MAX);
				ltr_pkg::OFS_INOM: s_nxt.inom = clampv(wm, ltr_pkg::INOM_MIN, ltr_pkg::INOM_MAX);
				ltr_pkg::OFS_TC: s_nxt.tc = clampv(wm, ltr_pkg::TC_MIN, ltr_pkg::TC_MAX);
				default: ;
			endcase
		end
	end

	// all state in one register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			s_r <= RST_S;
		else
			s_r <= s_nxt;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// status gating
	quiet_off_a: assert property (!en |=> !alarm_out && !trip_out && !lock_out)
		else $error("status active while off or blocked");
	pulse_once_a: assert property (
		s_r.st == ltr_pkg::ST_UPD && s_r.mode == ltr_pkg::MODE_PULSED && s_r.trip |=> !trip_out)
		else $error("pulsed trip held past one step");
	pulse_cause_a: assert property (
		$rose(trip_out) && s_r.mode == ltr_pkg::MODE_PULSED |-> s_r.above && !$past(s_r.above))
		else $error("pulse without crossing");
	lock_hold_a: assert property (
		s_r.mode == ltr_pkg::MODE_LOCKED && en && lock_out && s_r.st != ltr_pkg::ST_UPD
		|=> lock_out) else $error("locked trip dropped between steps");
	lock_trip_a: assert property (
		s_r.st == ltr_pkg::ST_UPD && en && s_r.mode == ltr_pkg::MODE_LOCKED && above_c
		|=> trip_out && lock_out) else $error("locked trip missing above threshold");
	alarm_set_a: assert property (
		s_r.st == ltr_pkg::ST_UPD && en && alarm_c |=> alarm_out)
		else $error("alarm missing above threshold");
	alarm_clr_a: assert property (
		s_r.st == ltr_pkg::ST_UPD && !alarm_c |=> !alarm_out)
		else $error("alarm kept below threshold");

	// model path, setting ranges and bus answer
	amb_floor_a: assert property (
		s_r.st == ltr_pkg::ST_UPD |=> s_r.temp >= 16'($past(amb_use)))
		else $error("temperature below ambient in use");
	max_sel_a: assert property (s_r.st == ltr_pkg::ST_XDIV |->
		s_r.imax >= s_r.rms[0] && s_r.imax >= s_r.rms[1] && s_r.imax >= s_r.rms[2])
		else $error("heating current not the largest phase");
	root_ok_a: assert property (s_r.st == ltr_pkg::ST_MAX |->
		32'(s_r.rms[0]) * 32'(s_r.rms[0]) <= s_r.ms[0] &&
		32'(s_r.rms[1]) * 32'(s_r.rms[1]) <= s_r.ms[1] &&
		32'(s_r.rms[2]) * 32'(s_r.rms[2]) <= s_r.ms[2])
		else $error("rms exceeds root of mean square");
	step_done_a: assert property (
		s_r.st == ltr_pkg::ST_IDLE && tick |-> ##[100:200] s_r.st == ltr_pkg::ST_UPD)
		else $error("model step did not complete");
	heat_load_a: assert property (
		s_r.st == ltr_pkg::ST_UPD && s_r.hrst |=> s_r.lvl == 40'($past(s_r.strt)) * ltr_pkg::PCT_Q32)
		else $error("heat reset did not reload start level");
	range_a: assert property (
		s_r.alm >= ltr_pkg::ALM_MIN && s_r.alm <= ltr_pkg::ALM_MAX && s_r.trp <= ltr_pkg::TRP_MAX
		&& s_r.base <= ltr_pkg::BASE_MAX && s_r.unl >= ltr_pkg::UNL_MIN
		&& s_r.inom >= ltr_pkg::INOM_MIN && s_r.tc >= ltr_pkg::TC_MIN && s_r.tc <= ltr_pkg::TC_MAX)
		else $error("setting out of range");
	bus_answer_a: assert property (req && avs_waitrequest |=> !req || !avs_waitrequest)
		else $error("bus answer late");

	// main scenarios
	pulse_c: cover property (s_r.mode == ltr_pkg::MODE_PULSED && $rose(trip_out));
	lock_c: cover property (s_r.mode == ltr_pkg::MODE_LOCKED && $fell(lock_out));
	alarm_c_c: cover property ($rose(alarm_out));
	hrst_c: cover property (s_r.st == ltr_pkg::ST_UPD && s_r.hrst);

endmodule // ltr_thermal_replica

// File: testbench/ltr_front_model.sv
// phase current front end model: three sample streams and an ambient probe
// assumes ref_clk drives it and the replica samples the streams on its step ticks
`timescale 1ns/1ps
module ltr_front_model (
	input wire logic ref_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [15:0] amp1, // phase 1 magnitude, counts
	input wire logic [15:0] amp2, // phase 2 magnitude, counts
	input wire logic [15:0] amp3, // phase 3 magnitude, counts
	input wire logic [7:0] amb, // probe temperature, deg
	output logic [15:0] phase1_sample, // signed sample
	output logic [15:0] phase2_sample, // signed sample
	output logic [15:0] phase3_sample, // signed sample
	output logic [7:0] ambient_sensor_temp // probe reading
);
	logic sign_r; // polarity of the square wave
	// square wave: rms equals the magnitude whichever cycle the tick hits
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sign_r <= 1'b0;
		end else begin
			sign_r <= ~sign_r;
		end
	end
	// negative half cycles by two's complement
	assign phase1_sample = sign_r ? (16'h0000 - amp1) : amp1;
	assign phase2_sample = sign_r ? (16'h0000 - amp2) : amp2;
	assign phase3_sample = sign_r ? (16'h0000 - amp3) : amp3;
	assign ambient_sensor_temp = amb;
endmodule // ltr_front_model

// File: testbench/testbench.sv
// self-checking bench of the line thermal replica
// assumes the replica answers avalon-mm with one wait cycle and steps every TICK cycles
`timescale 1ns/1ps
`define LTR_CHECK(what, exp, got) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
		end \
	end
module testbench;
	localparam int unsigned TICK = 400;
	localparam int unsigned LIMIT = 60000;
	typedef struct {logic [31:0] v; logic [31:0] m; string n;} ltr_note_t;
	logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0] avs_address = 8'h00, amb = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, l0, l1, dl, v;
	logic [3:0] avs_byteenable = 4'h0;
	logic [15:0] amp1 = 16'h0, amp2 = 16'h0, amp3 = 16'h0, rnd = 16'hBEC5;
	logic [15:0] s1, s2, s3;
	logic [7:0] ambs;
	logic avs_waitrequest, alarm_out, trip_out, lock_out, chk_pulse = 1'b0;
	int num_errors = 0, samples_checked = 0, cycles = 0, pulse_len = 0, pulses = 0;
	ltr_note_t notes[$];
	ltr_note_t nt;
	logic [7:0] offs [9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
	logic [9:0] dflt [9] = '{10'h050, 10'h064, 10'h064, 10'h019, 10'h03C, 10'h019, 10'h000,
		10'h064, 10'h00A};
	logic [9:0] mins [9] = '{10'h03C, 10'h03C, 10'h03C, 10'h000, 10'h014, 10'h000, 10'h000,
		10'h014, 10'h001};
	logic [9:0] maxs [9] = '{10'h0C8, 10'h0C8, 10'h0C8, 10'h028, 10'h0C8, 10'h028, 10'h03C,
		10'h096, 10'h3E7};

	ltr_thermal_replica #(.TICK_CYCLES(TICK)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.phase1_sample(s1), .phase2_sample(s2), .phase3_sample(s3),
		.ambient_sensor_temp(ambs), .alarm_out(alarm_out), .trip_out(trip_out),
		.lock_out(lock_out));
	ltr_front_model front (.ref_clk(ref_clk), .rst_b(rst_b), .amp1(amp1), .amp2(amp2),
		.amp3(amp3), .amb(amb), .phase1_sample(s1), .phase2_sample(s2), .phase3_sample(s3),
		.ambient_sensor_temp(ambs));

	always #5 ref_clk = ~ref_clk;

	// 16-bit maximal-length shift register
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// one avalon access; request held until waitrequest is sampled low at a rising edge
	task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		bus_cycle(1'b1, a, d, 4'hF);
	endtask

	// expected read result goes on the queue before the request
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string n);
		notes.push_back('{e, 32'hFFFF_FFFF, n});
		bus_cycle(1'b0, a, 32'h0, 4'hF);
	endtask

	// read for the bench's own arithmetic; value taken at the accepting edge
	task automatic reg_peek(input logic [7:0] a, output logic [31:0] r);
		notes.push_back('{32'h0, 32'h0, "peek"});
		bus_cycle(1'b0, a, 32'h0, 4'hF);
		r = avs_readdata;
	endtask

	task automatic steps(input int n);
		repeat (n * TICK) @(posedge ref_clk);
	endtask

	// status pins sampled mid-cycle, away from the updating edge
	task automatic pins_are(input logic [2:0] e);
		@(negedge ref_clk);
		`LTR_CHECK("lock trip alarm pins", e, {lock_out, trip_out, alarm_out})
	endtask

	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// read results: oldest note against the data at the accepting edge
	always @(posedge ref_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			nt = notes.pop_front();
			if (nt.m != 32'h0) `LTR_CHECK(nt.n, nt.v, avs_readdata & nt.m)
		end
	end

	// trip pulse width watcher
	always @(posedge ref_clk) begin
		if (trip_out === 1'b1) begin
			pulse_len++;
		end else if (pulse_len != 0) begin
			if (chk_pulse) `LTR_CHECK("trip pulse cycles", TICK, pulse_len)
			pulses++;
			pulse_len = 0;
		end
	end

	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		reg_rd(8'h00, 32'h1, "control default");
		reg_rd(8'h40, 32'h0, "unmapped");
		// mode code three is kept as locked
		reg_wr(8'h00, 32'h3);
		reg_rd(8'h00, 32'h2, "mode three as locked");
		reg_wr(8'h00, 32'h1);
		// defaults, saturation at both ends, random in-range value
		for (int i = 0; i < 9; i++) begin
			reg_rd(offs[i], {22'h0, dflt[i]}, "default");
			reg_wr(offs[i], 32'h0);
			reg_rd(offs[i], {22'h0, mins[i]}, "floor");
			reg_wr(offs[i], 32'h3FF);
			reg_rd(offs[i], {22'h0, maxs[i]}, "ceiling");
			rnd = lfsr_next(rnd);
			v = {22'h0, mins[i]} + 32'(rnd) % ({22'h0, maxs[i] - mins[i]} + 32'h1);
			reg_wr(offs[i], v);
			reg_rd(offs[i], v, "in range");
			reg_wr(offs[i], {22'h0, dflt[i]});
		end
		bus_cycle(1'b1, 8'h04, 32'hC8, 4'h0);
		reg_rd(8'h04, 32'h50, "no lanes");
		// ambient source selection
		steps(2);
		reg_rd(8'h2C, 32'h19, "cold temperature");
		amb <= 8'h21;
		reg_wr(8'h00, 32'h5);
		steps(2);
		reg_rd(8'h2C, 32'h21, "probe temperature");
		reg_wr(8'h00, 32'h1);
		reg_wr(8'h18, 32'h28);
		steps(2);
		reg_rd(8'h2C, 32'h28, "fixed ambient");
		reg_wr(8'h18, 32'h19);
		// locked mode: 60 % gives 70 deg, 40 % gives 55 deg
		reg_wr(8'h04, 32'h3C);
		reg_wr(8'h08, 32'h41);
		reg_wr(8'h14, 32'h32);
		reg_wr(8'h1C, 32'h3C);
		reg_wr(8'h00, 32'h12);
		steps(2);
		reg_rd(8'h28, 32'hF, "locked hot status");
		pins_are(3'b111);
		reg_wr(8'h1C, 32'h28);
		reg_wr(8'h00, 32'h12);
		steps(2);
		reg_rd(8'h28, 32'h6, "locked held status");
		reg_wr(8'h1C, 32'h0);
		reg_wr(8'h00, 32'h12);
		steps(2);
		reg_rd(8'h28, 32'h0, "unlocked status");
		// pulsed mode: one pulse of one step on the crossing only
		chk_pulse = 1'b1;
		pulses = 0;
		reg_wr(8'h1C, 32'h3C);
		reg_wr(8'h00, 32'h11);
		steps(4);
		reg_rd(8'h28, 32'h9, "pulsed status");
		`LTR_CHECK("trip pulses", 1, pulses)
		reg_wr(8'h00, 32'h9);
		steps(1);
		pins_are(3'b000);
		reg_wr(8'h00, 32'h0);
		steps(1);
		pins_are(3'b000);
		reg_wr(8'h00, 32'h1);
		steps(1);
		chk_pulse = 1'b0;
		pins_are(3'b001);
		// heating: max phase 2000 counts, rated 200 counts, ratio squared 100
		reg_wr(8'h1C, 32'h0);
		reg_wr(8'h20, 32'h14);
		reg_wr(8'h24, 32'h1);
		amp1 <= 16'd500;
		amp2 <= 16'd2000;
		amp3 <= 16'd1000;
		reg_wr(8'h00, 32'h10);
		steps(34);
		reg_rd(8'h34, 32'd500, "phase 1 rms");
		reg_rd(8'h38, 32'd2000, "phase 2 rms");
		reg_rd(8'h3C, 32'd1000, "phase 3 rms");
		reg_peek(8'h30, l0);
		// the two level snapshots lie exactly one step apart, so one update between them
		repeat (TICK - 3) @(posedge ref_clk);
		reg_peek(8'h30, l1);
		dl = (32'd1677721600 - l0) / 32'd60000;
		`LTR_CHECK("level step", 1'b1, (l1 - l0 + 32'd32 >= dl) && (l1 - l0 <= dl + 32'd32))
		stop_test();
	end
endmodule // testbench
